//--- logic/pcd_pkg.sv
// Package of constants for the position command pulse decoder.
package pcd_pkg;
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int MODE_W = 3;
    localparam int FILT_W = 16;
    localparam int CNT_W = 32;
    // Mode codes: even is positive logic, odd is negative logic.
    localparam logic [2:0] MODE_STEP_DIR_POS = 3'h0;
    localparam logic [2:0] MODE_STEP_DIR_NEG = 3'h1;
    localparam logic [2:0] MODE_QUAD_POS = 3'h2;
    localparam logic [2:0] MODE_QUAD_NEG = 3'h3;
    localparam logic [2:0] MODE_CWCCW_POS = 3'h4;
    localparam logic [2:0] MODE_CWCCW_NEG = 3'h5;
    localparam int MODE_INVERT_BIT = 0;
    // Rate limits in pulses per second.
    localparam int DIFF_MAX_PPS = 500_000;
    localparam int OC_MAX_PPS = 200_000;
    localparam int DIFF_MIN_CYCLES = CLK_FREQ_HZ / DIFF_MAX_PPS;
    localparam int OC_MIN_CYCLES = CLK_FREQ_HZ / OC_MAX_PPS;
    // Quadrature phase spacing in nanoseconds, assumed microsecond figures.
    localparam int T4_DIFF_NS = 500;
    localparam int T4_OC_NS = 1250;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    localparam int T4_DIFF_CYC = (T4_DIFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T4_OC_CYC = (T4_OC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] FILT_RESET = 16'h0000;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
endpackage

//--- logic/pcd_filt_if.sv
// Interface carrying one raw and one filtered command line.
`timescale 1ns/1ns
`default_nettype none
interface pcd_filt_if;
    logic rawLine;
    logic cleanLine;
    modport filt (input rawLine, output cleanLine);
    modport user (output rawLine, input cleanLine);
endinterface
`default_nettype wire

//--- logic/pcd_glitch_filter.sv
// Glitch filter for one command line.
`timescale 1ns/1ns
`default_nettype none
module pcd_glitch_filter #(
    parameter int FILT_W = pcd_pkg::FILT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [FILT_W-1:0] filtTime,
    pcd_filt_if.filt line
);
    import pcd_pkg::*;
    typedef struct packed {
        logic level;
        logic [FILT_W-1:0] count;
    } pcd_gf_s;
    pcd_gf_s st_ff, nxt_st;

    // A new level is accepted only after it has stood for filtTime cycles.
    always_comb begin
        nxt_st = st_ff;
        if (line.rawLine == st_ff.level) begin
            nxt_st.count = '0;
        end else if (st_ff.count >= filtTime) begin
            nxt_st.level = line.rawLine;
            nxt_st.count = '0;
        end else begin
            nxt_st.count = st_ff.count + FILT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign line.cleanLine = st_ff.level;

    a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(st_ff.level) |-> $past(st_ff.count) >= $past(filtTime))
        else $error("Filtered level changed before filter time elapsed.");
endmodule
`default_nettype wire

//--- logic/pcd_decoder.sv
// Top module decoding step/direction, quadrature and CW/CCW command pulses.
// Behaviour
// - Position commands arrive on a step line and a sign line.
// - Six modes: codes 0-1 step/dir, 2-3 quadrature, 4-5 CW/CCW; odd inverts.
// - Quadrature counts each edge of one phase alone, four counts per cycle; edges of both phases in one cycle are dropped.
// - Differential rates up to 500Kpps are decoded; host CW/CCW pulses reach the limit, other modes stay below.
// - Open collector rates up to 200Kpps are decoded; host CW/CCW pulses at 624 cycles run just above, other modes stay below.
// - Glitches shorter than the programmed filter time are ignored.
`timescale 1ns/1ns
`default_nettype none
module pcd_decoder #(
    parameter int CNT_W = pcd_pkg::CNT_W,
    parameter int FILT_W = pcd_pkg::FILT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdStep,
    input wire logic cmdSign,
    input wire logic [pcd_pkg::MODE_W-1:0] commandModeSelect,
    input wire logic [FILT_W-1:0] commandFilterTime,
    output logic countUp,
    output logic countDown,
    output logic [CNT_W-1:0] position,
    output logic modeError
);
    import pcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    pcd_filt_if stepIf();
    pcd_filt_if signIf();
    logic invert;

    // Negative logic inverts both lines before filtering and decoding.
    assign invert = commandModeSelect[MODE_INVERT_BIT];
    assign stepIf.rawLine = cmdStep ^ invert;
    assign signIf.rawLine = cmdSign ^ invert;

    // One glitch filter per command line; both share the programmed filter time.
    pcd_glitch_filter #(.FILT_W(FILT_W)) uStepFilt (
        .clk(clk),
        .rst_n(rst_n),
        .filtTime(commandFilterTime),
        .line(stepIf.filt)
    );
    pcd_glitch_filter #(.FILT_W(FILT_W)) uSignFilt (
        .clk(clk),
        .rst_n(rst_n),
        .filtTime(commandFilterTime),
        .line(signIf.filt)
    );

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {PCD_STEPDIR, PCD_QUAD, PCD_CWCCW, PCD_BAD} pcd_mode_e;
    // Previous filtered levels, a flag that masks the first edge after reset, and the counter.
    typedef struct packed {
        logic stepPrev;
        logic signPrev;
        logic primed;
        logic up;
        logic down;
        logic err;
        logic [CNT_W-1:0] pos;
    } pcd_dec_s;
    pcd_dec_s st_ff, nxt_st;
    pcd_mode_e mode;
    logic a, b, aRise, bRise, aEdge, bEdge;

    // Codes 6 and 7 are illegal and stop all counting.
    always_comb begin
        unique case (commandModeSelect)
            MODE_STEP_DIR_POS, MODE_STEP_DIR_NEG: mode = PCD_STEPDIR;
            MODE_QUAD_POS, MODE_QUAD_NEG: mode = PCD_QUAD;
            MODE_CWCCW_POS, MODE_CWCCW_NEG: mode = PCD_CWCCW;
            default: mode = PCD_BAD;
        endcase
    end

    // Edges are judged on filtered levels only, so a rejected glitch never reaches the counter.
    assign a = stepIf.cleanLine;
    assign b = signIf.cleanLine;
    assign aEdge = st_ff.primed && (a != st_ff.stepPrev);
    assign bEdge = st_ff.primed && (b != st_ff.signPrev);
    assign aRise = aEdge && a;
    assign bRise = bEdge && b;

    // Rate capacity: one count per clock far exceeds the 500Kpps limit.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stepPrev = a;
        nxt_st.signPrev = b;
        nxt_st.primed = 1'b1;
        nxt_st.up = 1'b0;
        nxt_st.down = 1'b0;
        nxt_st.err = (mode == PCD_BAD);
        unique case (mode)
            PCD_STEPDIR: begin
                // Sign low counts forward, high counts reverse.
                nxt_st.up = aRise && !b;
                nxt_st.down = aRise && b;
            end
            PCD_QUAD: begin
                // An edge of one phase alone is one count; edges of both phases in one cycle count nothing.
                if (aEdge && !bEdge) begin
                    nxt_st.up = (a != b);
                    nxt_st.down = (a == b);
                end else if (bEdge && !aEdge) begin
                    nxt_st.up = (a == b);
                    nxt_st.down = (a != b);
                end
            end
            PCD_CWCCW: begin
                // Rises on both lines in one cycle cannot be ordered, so they are dropped.
                nxt_st.up = aRise && !bRise;
                nxt_st.down = bRise && !aRise;
            end
            PCD_BAD: begin
                // No counts while the mode code is illegal.
                nxt_st.up = 1'b0;
            end
        endcase
        if (nxt_st.up) begin
            nxt_st.pos = st_ff.pos + CNT_W'(1);
        end else if (nxt_st.down) begin
            nxt_st.pos = st_ff.pos - CNT_W'(1);
        end
    end

    // Synchronous reset clears the counter and masks the first edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // All outputs come straight from the state register.
    assign countUp = st_ff.up;
    assign countDown = st_ff.down;
    assign position = st_ff.pos;
    assign modeError = st_ff.err;

    ////////////////////////////////////////////////////////////////////////
    // Assertions on the decoding of each mode.
    sequence s_quad_a_lead;
        $past(mode) == PCD_QUAD && $past(aEdge) && !$past(bEdge) && $past(a) != $past(b);
    endsequence

    a_quad_forward: assert property (@(posedge clk) disable iff (!rst_n)
        s_quad_a_lead |-> countUp && !countDown)
        else $error("Quadrature A-lead edge did not count forward.");
    a_quad_every_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_QUAD && (aEdge ^ bEdge)) |=> (countUp ^ countDown))
        else $error("Quadrature edge was not counted.");
    a_stepdir_dir: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_STEPDIR && aRise) |=> (countUp == !$past(b)) && (countDown == $past(b)))
        else $error("Step direction count wrong.");
    a_step_fall_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_STEPDIR && !aRise) |=> !countUp && !countDown)
        else $error("Step mode counted without a rising step.");
    a_cw_count: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_CWCCW && aRise && !bRise) |=> countUp)
        else $error("CW pulse did not count forward.");
    a_pos_track: assert property (@(posedge clk) disable iff (!rst_n)
        countUp |-> position == $past(position) + CNT_W'(1))
        else $error("Position did not follow forward count.");
    a_pos_down: assert property (@(posedge clk) disable iff (!rst_n)
        countDown |-> position == $past(position) - CNT_W'(1))
        else $error("Position did not follow reverse count.");
    // The sampled reset masks the release edge, where the register still holds its reset value.
    a_bad_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && mode == PCD_BAD) |=> modeError && !countUp && !countDown)
        else $error("Illegal mode code produced counts.");
    a_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
        !(countUp && countDown))
        else $error("Both count directions at once.");

    ////////////////////////////////////////////////////////////////////////
    // Reverse and B-phase counts, simultaneous edges, idle cycles and the mode error clear.
    sequence s_quad_a_same;
        $past(mode) == PCD_QUAD && $past(aEdge) && !$past(bEdge) && $past(a) == $past(b);
    endsequence

    sequence s_quad_b_same;
        $past(mode) == PCD_QUAD && $past(bEdge) && !$past(aEdge) && $past(a) == $past(b);
    endsequence

    sequence s_quad_b_diff;
        $past(mode) == PCD_QUAD && $past(bEdge) && !$past(aEdge) && $past(a) != $past(b);
    endsequence

    a_quad_reverse: assert property (@(posedge clk) disable iff (!rst_n)
        s_quad_a_same |-> countDown && !countUp)
        else $error("Quadrature A edge with equal phases did not count reverse.");
    a_quad_b_forward: assert property (@(posedge clk) disable iff (!rst_n)
        s_quad_b_same |-> countUp && !countDown)
        else $error("Quadrature B edge with equal phases did not count forward.");
    a_quad_b_reverse: assert property (@(posedge clk) disable iff (!rst_n)
        s_quad_b_diff |-> countDown && !countUp)
        else $error("Quadrature B edge with unequal phases did not count reverse.");
    a_quad_both_edges: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_QUAD && aEdge && bEdge) |=> !countUp && !countDown)
        else $error("Simultaneous quadrature edges produced a count.");

    a_ccw_count: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_CWCCW && bRise && !aRise) |=> countDown)
        else $error("CCW pulse did not count reverse.");
    a_cw_both_rise: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_CWCCW && aRise && bRise) |=> !countUp && !countDown)
        else $error("Simultaneous CW and CCW rises produced a count.");
    a_cw_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == PCD_CWCCW && !aRise && !bRise) |=> !countUp && !countDown)
        else $error("CW/CCW mode counted without a rising pulse.");
    a_pos_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!countUp && !countDown) |-> $stable(position))
        else $error("Position changed without a count.");
    a_mode_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (mode != PCD_BAD) |=> !modeError)
        else $error("Mode error flagged for a legal mode.");
endmodule
`default_nettype wire

//--- testbench/pcd_host_model.sv
// Host controller model that drives the command step and sign lines.
`timescale 1ns/1ns
`default_nettype none
module pcd_host_model (
    input wire logic clk,
    input wire logic inv,
    output logic stepLine,
    output logic signLine
);
    logic a = 1'b0;
    logic b = 1'b0;
    // Negative logic modes show the inverse level on both lines.
    assign stepLine = a ^ inv;
    assign signLine = b ^ inv;
    ////////////////////////////////////////////////////////////////
    // Each level is held g cycles; callers pick g from the rate and width limits.
    task automatic set(input logic na, input logic nb, input int g);
        a <= na;
        b <= nb;
        repeat (g) @(posedge clk);
    endtask
    task automatic send(input logic [2:0] mode, input logic dir, input int g);
        case (mode[2:1])
            2'd0: begin
                set(1'b0, dir, g);
                set(1'b1, dir, g);
                set(1'b0, dir, g);
            end
            2'd1: begin
                set(!dir, dir, g);
                set(1'b1, 1'b1, g);
                set(dir, !dir, g);
                set(1'b0, 1'b0, g);
            end
            default: begin
                set(!dir, dir, g);
                set(1'b0, 1'b0, g);
            end
        endcase
    endtask
endmodule
`default_nettype wire

//--- testbench/pcd_decoder_tb_top.sv
// Self-checking testbench of the position command pulse decoder.
`timescale 1ns/1ns
`default_nettype none
module pcd_decoder_tb_top;
    import pcd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] modeSel = 3'h0;
    logic [15:0] filt = 16'h0000;
    wire logic cmdStep;
    wire logic cmdSign;
    logic countUp;
    logic countDown;
    logic [31:0] position;
    logic modeError;
    logic [31:0] seed = 32'h667b_481e;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int expPos = 0;
    int fT = 1;
    int expQ[$];
    always #4 clk = ~clk;
    pcd_decoder i_dut (.clk(clk), .rst_n(rst_n), .cmdStep(cmdStep), .cmdSign(cmdSign),
        .commandModeSelect(modeSel), .commandFilterTime(filt), .countUp(countUp),
        .countDown(countDown), .position(position), .modeError(modeError));
    pcd_host_model i_host (.clk(clk), .inv(modeSel[0]), .stepLine(cmdStep), .signLine(cmdSign));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Lines return to idle while the design is held in reset.
    task automatic restart(input logic [2:0] m);
        rst_n <= 1'b0;
        modeSel <= m;
        expPos = 0;
        i_host.set(1'b0, 1'b0, 5);
        rst_n <= 1'b1;
        repeat (fT + 6) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // Every count pulse is matched against the queued expectation.
    always @(posedge clk) begin
        cycles++;
        if (rst_n === 1'b1 && (countUp === 1'b1 || countDown === 1'b1)) begin
            check(expQ.size() > 0 && countUp !== countDown && (countUp === (expQ[0] > 0)), "bad count");
            if (expQ.size() > 0) begin
                expPos += expQ.pop_front();
            end
            check(position === 32'(expPos), "position mismatch");
        end
        if (cycles == 80000) begin
            check(1'b0, "timeout");
            wrap_up();
        end
    end
    initial begin
        logic [31:0] r;
        int g;
        @(posedge clk);
        fT = 1 + int'(nextRand() % 8);
        filt <= 16'(fT);
        for (int m = 0; m < 8; m++) begin
            restart(3'(m));
            check(modeError === (m > 5), "mode error flag");
            for (int k = 0; k < 6; k++) begin
                r = nextRand();
                if (m / 2 == 1) begin
                    g = (k < 3) ? T4_DIFF_CYC : T4_OC_CYC;
                end else begin
                    g = (k < 3) ? DIFF_MIN_CYCLES / 2 : OC_MIN_CYCLES / 2;
                end
                if (m < 6) begin
                    repeat ((m / 2 == 1) ? 4 : 1) expQ.push_back(r[0] ? -1 : 1);
                end
                i_host.send(3'(m), r[0], g);
            end
            if (m == 0) begin
                i_host.set(1'b1, 1'b1, fT);
                i_host.set(1'b0, 1'b1, 3 * fT + 10);
            end else if (m == 2 || m == 4) begin
                i_host.set(1'b1, 1'b1, 2 * fT + 4);
                i_host.set(1'b0, 1'b0, 2 * fT + 4);
            end
            repeat (fT + 6) @(posedge clk);
            check(expQ.size() == 0 && position === 32'(expPos), "counts missing");
        end
        wrap_up();
    end
endmodule
`default_nettype wire
